// [cmp_ctrl_defines.svh]
`ifndef CMP_CTRL_DEFINES_SVH
`define CMP_CTRL_DEFINES_SVH
// Register offsets on the local register port.
`define OFS_CMP_ONE_CONTROL  9'h119
`define OFS_CMP_TWO_CONTROL  9'h11A
`define OFS_CMP_MIRROR_SYNC  9'h11B
`define OFS_PERIPH_FLAG      9'h00C
`define OFS_PERIPH_ENABLE    9'h08C
`define OFS_IRQ_CONTROL      9'h00B
`define OFS_LADDER_CONTROL   9'h099
// Field positions inside the comparator control registers.
`define BIT_CMP_ON           7
`define BIT_CMP_RESULT       6
`define BIT_CMP_PIN_EN       5
`define BIT_CMP_INVERT       4
// Field positions inside the mirror/sync register.
`define BIT_MIRROR_ONE       7
`define BIT_MIRROR_TWO       6
`define BIT_GATE_SELECT      1
`define BIT_SYNC_ENABLE      0
// Flag and enable positions of the two comparators, then the peripheral and global interrupt enables.
`define BIT_IRQ_ONE          3
`define BIT_IRQ_TWO          4
`define BIT_PERIPH_IRQ_EN    6
`define BIT_GLOBAL_IRQ_EN    7
// Ladder control fields.
`define BIT_LADDER_ONE       7
`define BIT_LADDER_TWO       6
`define BIT_LADDER_RANGE     5
`define BIT_LADDER_HOLE      4
// Reset values.
`define RST_CMP_CONTROL      8'h00
`define RST_MIRROR_SYNC      2'h2
`define RST_LADDER_CONTROL   8'h00
`define RST_BYTE             8'h00
// Writable masks.
`define MASK_CMP_CONTROL     8'hBF
`define MASK_LADDER_CONTROL  8'hEF
`endif

// [cmp_ctrl_pkg.sv]
package cmp_ctrl_pkg;
    // Register port request from software.
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    // Raw analog comparator decisions and port direction bits.
    typedef struct packed {
        logic raw_one;
        logic raw_two;
        logic dir_one_input;
        logic dir_two_input;
    } analog_in_type;

    // Whole block state.
    typedef struct packed {
        logic [7:0] ctl_one;
        logic [7:0] ctl_two;
        logic [1:0] mirror_sync;
        logic [7:0] ladder;
        logic [1:0] flags;
        logic [1:0] irq_en;
        logic       periph_en;
        logic       global_en;
        logic [1:0] result;
        logic [1:0] mismatch;
        logic [1:0] differ;
        logic       sync_two;
        logic       tclk_prev;
        logic [7:0] rdata;
        logic       irq;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic       gate;
        logic       ladder_power;
    } state_type;
endpackage

// [cmp_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cmp_ctrl_defines.svh"
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input  wire logic                       core_clk,     // Instruction clock.
    input  wire logic                       rst_n,        // Async reset.
    input  wire cmp_ctrl_pkg::reg_req_type  req,          // Register request.
    input  wire cmp_ctrl_pkg::analog_in_type ana,         // Comparators, dirs.
    input  wire logic                       timer_clk,    // Prescaled clock.
    input  wire logic                       gate_pin,     // External gate.
    input  wire logic                       ladder_pin_output_enable, // Pin.
    output var  logic [7:0]                 rdata,        // Read data.
    output var  logic                       irq,          // Interrupt request.
    output var  logic [1:0]                 pin_out,      // Result pins.
    output var  logic [1:0]                 pin_oe,       // Pin drive enable.
    output var  logic                       gate,         // Timer gate.
    output var  logic                       ladder_power, // Ladder powered.
    output var  logic [7:0]                 ladder_ctl    // Ladder settings.
);
    import cmp_ctrl_pkg::*;

    state_type st_reg;
    state_type st_next;

    // Assertions below all sample on the instruction clock.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Applies the inversion bit to a raw comparator decision.
    function automatic logic polar(input logic raw, input logic [7:0] ctl);
        polar = ctl[`BIT_CMP_ON] & (raw ^ ctl[`BIT_CMP_INVERT]);
    endfunction

    logic [1:0] live;
    logic       hit_one;
    logic       hit_two;
    logic       hit_flag;

    // Address decode shared by read and write paths.
    assign hit_one  = (req.addr == `OFS_CMP_ONE_CONTROL);
    assign hit_two  = (req.addr == `OFS_CMP_TWO_CONTROL);
    assign hit_flag = (req.addr == `OFS_PERIPH_FLAG);

    // Next-state logic for the whole block.
    always_comb begin
        st_next = st_reg;
        live[0] = polar(ana.raw_one, st_reg.ctl_one);
        live[1] = polar(ana.raw_two, st_reg.ctl_two);
        // Result latched at the end of every instruction cycle.
        st_next.result = live;
        // The timer clock is sampled, so its edge is seen one cycle late.
        // Comparator two sync: capture on timer clock falling edge.
        st_next.tclk_prev = timer_clk;
        if (st_reg.tclk_prev && !timer_clk) begin
            st_next.sync_two = st_reg.result[1];
        end
        // Mismatch edge detection against the refresh latches.
        st_next.differ = st_reg.result ^ st_reg.mismatch;
        // Register writes.
        if (req.wr) begin
            case (req.addr)
                `OFS_CMP_ONE_CONTROL:
                    st_next.ctl_one = req.wdata & `MASK_CMP_CONTROL;
                `OFS_CMP_TWO_CONTROL:
                    st_next.ctl_two = req.wdata & `MASK_CMP_CONTROL;
                `OFS_CMP_MIRROR_SYNC: begin
                    st_next.mirror_sync = req.wdata[1:0];
                end
                `OFS_PERIPH_FLAG:
                    st_next.flags = req.wdata[4:3];
                `OFS_PERIPH_ENABLE:
                    st_next.irq_en = req.wdata[4:3];
                `OFS_IRQ_CONTROL: begin
                    st_next.periph_en = req.wdata[`BIT_PERIPH_IRQ_EN];
                    st_next.global_en = req.wdata[`BIT_GLOBAL_IRQ_EN];
                end
                `OFS_LADDER_CONTROL:
                    st_next.ladder = req.wdata & `MASK_LADDER_CONTROL;
                default: begin
                end
            endcase
        end
        // Access to a comparator's own control register refreshes its latch.
        // Clearing differ here keeps the refresh from raising a false edge.
        if ((req.wr || req.rd) && hit_one) begin
            st_next.mismatch[0] = st_reg.result[0];
            st_next.differ[0]   = 1'b0;
        end
        if ((req.wr || req.rd) && hit_two) begin
            st_next.mismatch[1] = st_reg.result[1];
            st_next.differ[1]   = 1'b0;
        end
        // Edge of mismatch sets the flag; a set beats a software clear.
        // A change coinciding with a control read is dropped (lost event).
        if (st_next.differ[0] && !st_reg.differ[0] &&
            !(req.rd && hit_one)) begin
            st_next.flags[0] = 1'b1;
        end
        if (st_next.differ[1] && !st_reg.differ[1] &&
            !(req.rd && hit_two)) begin
            st_next.flags[1] = 1'b1;
        end
        // Interrupt request needs all three enables.
        st_next.irq = |(st_next.flags & st_next.irq_en) &&
                      st_next.periph_en && st_next.global_en;
        // Pins carry the unsynchronised live result; direction gates driver.
        st_next.pin_out   = live;
        st_next.pin_oe[0] = st_next.ctl_one[`BIT_CMP_PIN_EN] &
                            st_next.ctl_one[`BIT_CMP_ON] &
                            !ana.dir_one_input;
        st_next.pin_oe[1] = st_next.ctl_two[`BIT_CMP_PIN_EN] &
                            st_next.ctl_two[`BIT_CMP_ON] &
                            !ana.dir_two_input;
        // Software is expected to set sync whenever comparator two gates.
        // Gate source: external pin or comparator two path.
        if (st_next.mirror_sync[`BIT_GATE_SELECT]) begin
            st_next.gate = gate_pin;
        end else if (st_next.mirror_sync[`BIT_SYNC_ENABLE]) begin
            st_next.gate = st_next.sync_two;
        end else begin
            st_next.gate = st_next.result[1];
        end
        // Ladder powered only while someone uses it.
        // The ladder's analog output itself lives outside this block.
        st_next.ladder_power = st_next.ladder[`BIT_LADDER_ONE] |
                               st_next.ladder[`BIT_LADDER_TWO] |
                               ladder_pin_output_enable;
        // Read data, valid the cycle after the strobe.
        // Reads of unmapped addresses return zero.
        st_next.rdata = `RST_BYTE;
        if (req.rd) begin
            case (req.addr)
                `OFS_CMP_ONE_CONTROL:
                    st_next.rdata = {st_reg.ctl_one[7], st_reg.result[0],
                                     st_reg.ctl_one[5:0]};
                `OFS_CMP_TWO_CONTROL:
                    st_next.rdata = {st_reg.ctl_two[7], st_reg.result[1],
                                     st_reg.ctl_two[5:0]};
                `OFS_CMP_MIRROR_SYNC:
                    st_next.rdata = {st_reg.result[0], st_reg.result[1],
                                     4'h0, st_reg.mirror_sync};
                `OFS_PERIPH_FLAG:
                    st_next.rdata = {3'h0, st_reg.flags, 3'h0};
                `OFS_PERIPH_ENABLE:
                    st_next.rdata = {3'h0, st_reg.irq_en, 3'h0};
                `OFS_IRQ_CONTROL:
                    st_next.rdata = {st_reg.global_en, st_reg.periph_en,
                                     6'h00};
                `OFS_LADDER_CONTROL:
                    st_next.rdata = st_reg.ladder;
                default:
                    st_next.rdata = `RST_BYTE;
            endcase
        end
    end

    // State register; reset clears everything except mirror_sync, which loads 2'h2 (gate pin selected).
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg             <= '0;
            st_reg.ctl_one     <= `RST_CMP_CONTROL;
            st_reg.ctl_two     <= `RST_CMP_CONTROL;
            // Mirror/sync resets with the gate pin selected.
            st_reg.mirror_sync <= `RST_MIRROR_SYNC;
            st_reg.ladder      <= `RST_LADDER_CONTROL;
            st_reg.gate        <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops.
    assign rdata        = st_reg.rdata;
    assign irq          = st_reg.irq;
    assign pin_out      = st_reg.pin_out;
    assign pin_oe       = st_reg.pin_oe;
    assign gate         = st_reg.gate;
    assign ladder_power = st_reg.ladder_power;
    assign ladder_ctl   = st_reg.ladder;

    // Checks: each property samples on the instruction clock, reset off.

    // A request only leaves while both upper enables are set.
    a_irq_needs_enables: assert property (
        irq |-> st_reg.periph_en && st_reg.global_en)
        else $error("irq without enables");

    // A request also needs a flag whose own enable is set.
    a_irq_needs_flag: assert property (
        irq |-> |(st_reg.flags & st_reg.irq_en))
        else $error("irq without enabled flag");

    // The unimplemented ladder bit reads back as zero.
    a_ladder_hole_zero: assert property (
        $past(req.rd) && $past(req.addr) == `OFS_LADDER_CONTROL |->
        rdata[`BIT_LADDER_HOLE] == 1'b0)
        else $error("ladder bit 4 not zero");

    // A write never stores the unimplemented ladder bit.
    a_ladder_keeps_hole: assert property (
        req.wr && req.addr == `OFS_LADDER_CONTROL |=>
        !ladder_ctl[`BIT_LADDER_HOLE])
        else $error("ladder bit 4 stored");

    // A ladder read returns the settings that drive the ladder.
    a_ladder_readback: assert property (
        $past(req.rd) && $past(req.addr) == `OFS_LADDER_CONTROL |->
        rdata == ladder_ctl)
        else $error("ladder read differs");

    // Software writing ones sets both flags.
    a_flag_write_one: assert property (
        req.wr && hit_flag && req.wdata[4:3] == 2'h3 |=>
        st_reg.flags == 2'h3)
        else $error("flag write one lost");

    // Software writing zero clears flag one unless a change lands too.
    a_flag_write_zero: assert property (
        req.wr && hit_flag && !req.wdata[`BIT_IRQ_ONE] &&
        !(st_next.differ[0] && !st_reg.differ[0]) |=> !st_reg.flags[0])
        else $error("flag write zero lost");

    // Each new mismatch of comparator one sets its flag.
    a_flag_one_rise: assert property (
        $rose(st_reg.differ[0]) |-> st_reg.flags[0])
        else $error("flag one missed a change");

    // Each new mismatch of comparator two sets its flag.
    a_flag_two_rise: assert property (
        $rose(st_reg.differ[1]) |-> st_reg.flags[1])
        else $error("flag two missed a change");

    // A mismatch that merely persists never sets a cleared flag again.
    a_flag_no_level: assert property (
        !st_reg.flags[0] && st_reg.differ[0] && !(req.wr && hit_flag) |=>
        !st_reg.flags[0])
        else $error("flag set by a level");

    // An own control read refreshes the latch, so no edge can follow it.
    a_read_drops_edge: assert property (
        req.rd && hit_one |=> !st_reg.differ[0])
        else $error("edge kept across control read");

    // Mirror reads leave both mismatch latches alone.
    a_mirror_keeps_latch: assert property (
        req.rd && req.addr == `OFS_CMP_MIRROR_SYNC |=>
        $stable(st_reg.mismatch))
        else $error("mirror read touched latch");

    // A read of control one copies its result into the latch.
    a_refresh_latch: assert property (
        req.rd && hit_one |=> st_reg.mismatch[0] == $past(st_reg.result[0]))
        else $error("latch not refreshed");

    // Any access to control two refreshes its latch.
    a_refresh_two: assert property (
        (req.rd || req.wr) && hit_two |=>
        st_reg.mismatch[1] == $past(st_reg.result[1]))
        else $error("latch two not refreshed");

    // The mirror shows both latched results at once.
    a_mirror_read: assert property (
        $past(req.rd) && $past(req.addr) == `OFS_CMP_MIRROR_SYNC |->
        rdata[7:6] == $past({st_reg.result[0], st_reg.result[1]}))
        else $error("mirror result bits wrong");

    // Control one shows its own result bit.
    a_own_result_read: assert property (
        $past(req.rd) && $past(hit_one) |->
        rdata[`BIT_CMP_RESULT] == $past(st_reg.result[0]))
        else $error("own result bit wrong");

    // With no user left the ladder is switched off.
    a_power_down: assert property (
        !st_reg.ladder[7] && !st_reg.ladder[6] && !ladder_pin_output_enable
        ##1 $stable(st_reg.ladder) |-> !ladder_power)
        else $error("ladder powered while unused");

    // A comparator that routes the ladder keeps it powered.
    a_power_in_use: assert property (
        st_reg.ladder[`BIT_LADDER_ONE] || st_reg.ladder[`BIT_LADDER_TWO] |->
        ladder_power)
        else $error("ladder unpowered while routed");

    // A set source bit hands the gate to the external pin.
    a_gate_pin_pick: assert property (
        st_next.mirror_sync[1] |=> gate == $past(gate_pin))
        else $error("gate source wrong");

    // Sync off: the gate follows the latched result of comparator two.
    a_gate_async: assert property (
        st_next.mirror_sync == 2'b00 |=> gate == st_reg.result[1])
        else $error("async gate path wrong");

    // Sync on: the gate holds between falling timer clock edges.
    a_gate_sync_hold: assert property (
        st_reg.mirror_sync == 2'b01 && st_next.mirror_sync == 2'b01 &&
        !(st_reg.tclk_prev && !timer_clk) |=> $stable(gate))
        else $error("sync gate moved off a falling edge");

    // A falling timer clock captures the result of comparator two.
    a_sync_on_fall: assert property (
        st_reg.tclk_prev && !timer_clk |=>
        st_reg.sync_two == $past(st_reg.result[1]))
        else $error("sync capture missed");

    // Pin one shows the polarised result of the cycle before.
    a_pin_raw_result: assert property (
        ##1 pin_out[0] == $past(polar(ana.raw_one, st_reg.ctl_one)))
        else $error("pin not raw result");

    // Pin two shows the polarised result of the cycle before.
    a_pin_two_raw: assert property (
        ##1 pin_out[1] == $past(polar(ana.raw_two, st_reg.ctl_two)))
        else $error("pin two not raw result");

    // A direction bit set to input stops pin one's driver.
    a_pin_dir_one: assert property (
        ana.dir_one_input |=> !pin_oe[0])
        else $error("pin one driven as input");

    // A direction bit set to input stops pin two's driver.
    a_pin_dir_two: assert property (
        ana.dir_two_input |=> !pin_oe[1])
        else $error("pin two driven as input");

    // A disabled comparator reads as zero.
    a_off_result_zero: assert property (
        !st_reg.ctl_one[`BIT_CMP_ON] |=> !st_reg.result[0])
        else $error("disabled comparator not zero");

    // The internal result is latched once per instruction cycle.
    a_result_latched: assert property (
        ##1 st_reg.result[1] == $past(polar(ana.raw_two, st_reg.ctl_two)))
        else $error("result not latched");

    // Main scenarios worth seeing.
    c_flag_one_set: cover property ($rose(st_reg.flags[0]));
    c_irq_raised: cover property ($rose(irq));
    c_sync_capture: cover property (
        st_reg.mirror_sync[0] && $changed(st_reg.sync_two));
    c_return_flag: cover property (
        st_reg.mismatch[0] && $rose(st_reg.flags[0]));
    c_gate_from_pin: cover property (st_reg.mirror_sync[1] && $rose(gate));
endmodule
`default_nettype wire

// [cmp_far_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cmp_far_model #(
    parameter int HALF = 8
) (
    input  wire logic                  core_clk,  // Instruction clock.
    input  wire logic                  rst_n,     // Async reset.
    input  wire logic [1:0]            raw,       // Commanded decisions.
    input  wire logic [1:0]            dir_in,    // Direction, 1 = input.
    input  wire logic                  gate,      // Gate from the block.
    output var  cmp_ctrl_pkg::analog_in_type ana, // Comparator levels.
    output var  logic                  timer_clk, // Prescaled timer clock.
    output var  logic [15:0]           count      // Gated timer count.
);
    import cmp_ctrl_pkg::*;
    logic [7:0] div_cnt;
    // The prescaler divides the instruction clock down to the timer clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
            timer_clk <= 1'b0;
        end else if (div_cnt == 8'(HALF - 1)) begin
            div_cnt <= 8'h00;
            timer_clk <= ~timer_clk;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    // The gated timer counts only on rising edges of its clock.
    always_ff @(posedge timer_clk or negedge rst_n) begin
        if (!rst_n) count <= 16'h0000;
        else if (gate) count <= count + 16'h0001;
    end
    // The analog cores hand over their decisions as plain levels.
    assign ana = {raw[0], raw[1], dir_in[0], dir_in[1]};
endmodule
`default_nettype wire

// [cmp_ctrl_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cmp_ctrl_defines.svh"
module cmp_ctrl_test;
    import cmp_ctrl_pkg::*;
    logic          core_clk, rst_n, gate_pin, lpoe, timer_clk, irq;
    logic          gate, ladder_power;
    reg_req_type   req;
    analog_in_type ana;
    logic [1:0]    raw, dir_in, pin_out, pin_oe;
    logic [7:0]    rdata, ladder_ctl, d;
    logic [15:0]   count;
    int            n_errors, n_tests;
    cmp_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .req(req), .ana(ana),
        .timer_clk(timer_clk), .gate_pin(gate_pin),
        .ladder_pin_output_enable(lpoe), .rdata(rdata), .irq(irq),
        .pin_out(pin_out), .pin_oe(pin_oe), .gate(gate),
        .ladder_power(ladder_power), .ladder_ctl(ladder_ctl));
    cmp_far_model #(.HALF(8)) far (.core_clk(core_clk), .rst_n(rst_n),
        .raw(raw), .dir_in(dir_in), .gate(gate), .ana(ana),
        .timer_clk(timer_clk), .count(count));
    // Compares one value and reports a difference at once.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits n edges and steps past them so outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One-cycle register write.
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge core_clk) req <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk) req.wr <= 1'b0;
    endtask
    // One-cycle read; data stand only in the following cycle.
    task automatic rd(input logic [8:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk) req.rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    task automatic t_reset();
        rd(`OFS_LADDER_CONTROL, 8'h00, "ladder");
        rd(`OFS_CMP_MIRROR_SYNC, 8'h02, "mirror");
        rd(`OFS_CMP_ONE_CONTROL, 8'h00, "ctl_one");
        rd(9'h1FF, 8'h00, "unmapped");
        chk("pin_oe", 8'h00, {6'h00, pin_oe});
    endtask
    task automatic t_ladder();
        wr(`OFS_LADDER_CONTROL, 8'hFF);
        rd(`OFS_LADDER_CONTROL, 8'hEF, "ladder_hole");
        chk("ladder_ctl", 8'hEF, ladder_ctl);
        chk("power_on", 8'h01, {7'h00, ladder_power});
        wr(`OFS_LADDER_CONTROL, 8'h20);
        tick(2);
        chk("power_off", 8'h00, {7'h00, ladder_power});
        @(posedge core_clk) lpoe <= 1'b1;
        tick(3);
        chk("power_pin", 8'h01, {7'h00, ladder_power});
    endtask
    task automatic t_pins();
        @(posedge core_clk) dir_in <= 2'b00;
        raw[0] <= 1'b1;
        wr(`OFS_CMP_ONE_CONTROL, 8'hA0);
        tick(3);
        chk("pin_raw", 8'h01, {7'h00, pin_out[0]});
        chk("pin_oe_on", 8'h01, {7'h00, pin_oe[0]});
        rd(`OFS_CMP_ONE_CONTROL, 8'hE0, "ctl_result");
        rd(`OFS_CMP_MIRROR_SYNC, 8'h82, "mirror_one");
        wr(`OFS_CMP_ONE_CONTROL, 8'hB0);
        tick(3);
        chk("pin_inv", 8'h00, {7'h00, pin_out[0]});
        rd(`OFS_CMP_ONE_CONTROL, 8'hB0, "ctl_inv");
        @(posedge core_clk) dir_in[0] <= 1'b1;
        tick(3);
        chk("pin_oe_dir", 8'h00, {7'h00, pin_oe[0]});
    endtask
    // Drives comparator one to v and expects the flag set or not.
    task automatic edge_one(input logic v, input logic [7:0] e, input string nm);
        @(posedge core_clk) raw[0] <= v;
        tick(5);
        rd(`OFS_PERIPH_FLAG, e, nm);
    endtask
    task automatic t_irq();
        @(posedge core_clk) raw[0] <= 1'b0;
        wr(`OFS_CMP_ONE_CONTROL, 8'h80);
        tick(100);
        rd(`OFS_CMP_ONE_CONTROL, 8'h80, "refresh");
        wr(`OFS_PERIPH_FLAG, 8'h00);
        wr(`OFS_PERIPH_ENABLE, 8'h18);
        wr(`OFS_IRQ_CONTROL, 8'hC0);
        edge_one(1'b1, 8'h08, "flag_set");
        chk("irq_on", 8'h01, {7'h00, irq});
        wr(`OFS_IRQ_CONTROL, 8'h80);
        tick(3);
        chk("irq_masked", 8'h00, {7'h00, irq});
        wr(`OFS_IRQ_CONTROL, 8'hC0);
        wr(`OFS_PERIPH_FLAG, 8'h00);
        tick(3);
        rd(`OFS_PERIPH_FLAG, 8'h00, "flag_clear");
        rd(`OFS_CMP_MIRROR_SYNC, 8'h82, "mirror_read");
        edge_one(1'b0, 8'h00, "no_return");
        edge_one(1'b1, 8'h08, "flag_again");
        wr(`OFS_PERIPH_FLAG, 8'h00);
        rd(`OFS_CMP_ONE_CONTROL, 8'hC0, "refresh_hi");
        edge_one(1'b0, 8'h08, "return_irq");
        wr(`OFS_PERIPH_FLAG, 8'h10);
        rd(`OFS_PERIPH_FLAG, 8'h10, "flag_soft");
    endtask
    task automatic t_gate();
        @(posedge core_clk) gate_pin <= 1'b1;
        tick(3);
        chk("gate_pin", 8'h01, {7'h00, gate});
        wr(`OFS_CMP_TWO_CONTROL, 8'h80);
        wr(`OFS_CMP_MIRROR_SYNC, 8'h00);
        tick(4);
        chk("gate_cmp_lo", 8'h00, {7'h00, gate});
        wr(`OFS_CMP_MIRROR_SYNC, 8'h01);
        @(posedge timer_clk);
        @(posedge core_clk) raw[1] <= 1'b1;
        tick(5);
        chk("gate_held", 8'h00, {7'h00, gate});
        @(negedge timer_clk);
        tick(4);
        chk("gate_sync", 8'h01, {7'h00, gate});
        chk("pin_two", 8'h01, {7'h00, pin_out[1]});
        tick(20);
        chk("count_run", 8'h01, {7'h00, count != 16'h0000});
    endtask
    // Prints the verdict and ends the run.
    task automatic test_done();
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Free-running instruction clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
    // Main sequence.
    initial begin
        {rst_n, gate_pin, lpoe, raw} = 5'h00;
        req = '0;
        dir_in = 2'b11;
        n_errors = 0;
        n_tests = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_ladder();
        t_pins();
        t_irq();
        t_gate();
        test_done();
    end
endmodule
`default_nettype wire
